//--- crate_ctrl_internal_regs.sv
`timescale 1ns/100ps

module crate_ctrl_internal_regs #(
  parameter int DATA_W  = 32,
  parameter int FIFO_D  = 4,
  parameter int SEC_CYC = crate_regs_pkg::SECOND_CYC,
  parameter int CRS_CYC = crate_regs_pkg::COARSE_CYC
) (
  // Clock, reset, enable
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  // Command port (one NAF per strobe)
  input  wire logic              cmd_valid,
  input  wire logic [4:0]        cmd_n,
  input  wire logic [3:0]        cmd_a,
  input  wire logic [4:0]        cmd_f,
  input  wire logic [15:0]       cmd_word,
  input  wire logic [DATA_W-1:0] cmd_data,
  input  wire logic              cmd_repeat,
  input  wire logic              stack_start,
  input  wire logic              repeat_done,
  output logic                   cmd_stall,
  output logic                   rd_valid,
  output logic [DATA_W-1:0]      rd_data,
  // Stack memory load port
  input  wire logic              stack_we,
  input  wire logic [9:0]        stack_addr,
  input  wire logic [15:0]       stack_wdata,
  output logic [15:0]            stack_rdata,
  // Acquisition inputs
  input  wire logic              acquire,
  input  wire logic [23:0]       lam_req,
  input  wire logic              nim_in,
  input  wire logic              gen_a_trig,
  input  wire logic              gen_b_trig,
  input  wire logic              count_a_in,
  input  wire logic              count_b_in,
  input  wire logic              buffer_done,
  input  wire logic              event_end,
  output logic                   event_trigger,
  output logic                   packet_end,
  // Generator outputs
  output logic                   delay_gate_gen_a,
  output logic                   delay_gate_gen_b,
  input  wire logic [1:0]        pulser_mode,
  // Dataway crate and broadcast actions
  output logic                   crate_init,
  output logic                   crate_clear,
  output logic                   crate_inhibit,
  output logic                   bcast_valid,
  output logic [23:0]            bcast_sel,
  output logic [3:0]             bcast_a,
  output logic [4:0]             bcast_f,
  output logic [DATA_W-1:0]      bcast_data,
  // Output data stream (bit 32 flags a 32-bit marker)
  output logic                   out_valid,
  output logic [DATA_W:0]        out_data,
  input  wire logic              out_ready
);

  // Assertions below sample on the system clock
  default clocking dflt_clk @(posedge clk_sys);
  endclocking

  // ****************************************************************
  // Command decode
  // ****************************************************************
  wire cmd      = cmd_valid && clk_en;
  wire is_intw  = cmd && cmd_n == crate_regs_pkg::STN_INTERN && cmd_f == crate_regs_pkg::FN_WRITE;
  wire is_intr  = cmd && cmd_n == crate_regs_pkg::STN_INTERN && cmd_f == crate_regs_pkg::FN_READ;
  wire is_map   = cmd && cmd_n == crate_regs_pkg::STN_MAP && cmd_f[crate_regs_pkg::MAP_WR_BIT];
  wire is_mark  = cmd && cmd_n == crate_regs_pkg::STN_MARK && cmd_a == 4'h0
                  && cmd_f == crate_regs_pkg::FN_WRITE;
  wire is_pause = cmd && cmd_n == crate_regs_pkg::STN_MARK && cmd_f == crate_regs_pkg::FN_READ;
  wire is_bc    = cmd && cmd_n == crate_regs_pkg::STN_BCAST;
  wire is_z     = cmd && cmd_n == crate_regs_pkg::STN_CRATE && cmd_a == crate_regs_pkg::SA_INIT
                  && cmd_f == crate_regs_pkg::FN_CRATE;
  wire is_c     = cmd && cmd_n == crate_regs_pkg::STN_CRATE && cmd_a == crate_regs_pkg::SA_CLEAR
                  && cmd_f == crate_regs_pkg::FN_CRATE;
  wire is_inh   = cmd && cmd_n == crate_regs_pkg::STN_INHIB && cmd_a == crate_regs_pkg::SA_CLEAR;
  wire is_seti  = is_inh && cmd_f == crate_regs_pkg::FN_SET_I;
  wire is_clri  = is_inh && cmd_f == crate_regs_pkg::FN_CLR_I;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [31:0] gen_a_timing_r, gen_b_timing_r, coarse_delay_ext_r, bulk_transfer_setup_r;
  logic [23:0] lam_trigger_mask_r, broadcast_select_map_r, broadcast_map_copy_r;
  logic [31:0] count_a_value_r, count_b_value_r, run_a_r, run_b_r;
  logic [1:0]  map_byte_r;
  logic [15:0] stack_mem_r [crate_regs_pkg::STACK_DEPTH];

  // Register writes through station 25 function 16
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      gen_a_timing_r        <= '0;
      gen_b_timing_r        <= '0;
      coarse_delay_ext_r    <= '0;
      bulk_transfer_setup_r <= '0;
      lam_trigger_mask_r    <= '0;
    end
    else if (is_intw)
    begin
      case (cmd_a)
        crate_regs_pkg::SA_GEN_A:  gen_a_timing_r        <= cmd_data;
        crate_regs_pkg::SA_GEN_B:  gen_b_timing_r        <= cmd_data;
        crate_regs_pkg::SA_COARSE: coarse_delay_ext_r    <= cmd_data;
        crate_regs_pkg::SA_BULK:   bulk_transfer_setup_r <= cmd_data;
        crate_regs_pkg::SA_LAM:    lam_trigger_mask_r    <= cmd_data[23:0];
        default: ;
      endcase
    end
  end

  // Byte-serial map load; any other command rewinds the byte counter
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      map_byte_r             <= '0;
      broadcast_select_map_r <= '0;
      broadcast_map_copy_r   <= '0;
    end
    else if (is_map)
    begin
      broadcast_select_map_r[8*map_byte_r +: 8] <= {cmd_f[3:0], cmd_a};
      broadcast_map_copy_r[8*map_byte_r +: 8]   <= {cmd_f[3:0], cmd_a};
      map_byte_r <= (map_byte_r == 2'h2) ? 2'h0 : map_byte_r + 2'h1;
    end
    else if (cmd)
      map_byte_r <= '0;
  end

  // Read mux, unmapped subaddresses read zero
  logic [31:0] rd_mux;
  assign rd_mux = (cmd_a == crate_regs_pkg::SA_GEN_A)   ? gen_a_timing_r :
                  (cmd_a == crate_regs_pkg::SA_GEN_B)   ? gen_b_timing_r :
                  (cmd_a == crate_regs_pkg::SA_LAM)     ? {8'h00, lam_trigger_mask_r} :
                  (cmd_a == crate_regs_pkg::SA_CNT_A)   ? count_a_value_r :
                  (cmd_a == crate_regs_pkg::SA_CNT_B)   ? count_b_value_r :
                  (cmd_a == crate_regs_pkg::SA_COARSE)  ? coarse_delay_ext_r :
                  (cmd_a == crate_regs_pkg::SA_BULK)    ? bulk_transfer_setup_r :
                  (cmd_a == crate_regs_pkg::SA_MAPCOPY) ? {8'h00, broadcast_map_copy_r} :
                  32'h0000_0000;

  // Stack storage, registered read
  always_ff @(posedge clk_sys)
  begin
    if (clk_en)
    begin
      if (stack_we)
        stack_mem_r[stack_addr] <= stack_wdata;
      stack_rdata <= stack_mem_r[stack_addr];
    end
  end

  // ****************************************************************
  // Trigger, counters and latching
  // ****************************************************************
  wire lam_hit = (lam_trigger_mask_r != '0) && ((lam_req & lam_trigger_mask_r) == lam_trigger_mask_r);
  wire trig    = acquire && ((lam_trigger_mask_r == '0) ? nim_in : lam_hit);
  wire latch   = acquire ? trig : stack_start;

  // Free running counters with snapshot registers
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      run_a_r <= '0;
      run_b_r <= '0;
      count_a_value_r <= '0;
      count_b_value_r <= '0;
      event_trigger   <= 1'b0;
    end
    else if (clk_en)
    begin
      run_a_r       <= run_a_r + 32'(count_a_in);
      run_b_r       <= run_b_r + 32'(count_b_in);
      event_trigger <= trig;
      if (latch)
      begin
        count_a_value_r <= run_a_r;
        count_b_value_r <= run_b_r;
      end
    end
  end

  // ****************************************************************
  // Delay and gate generators
  // ****************************************************************
  logic [1:0] gen_out_r;
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_ch
      wire  [31:0] tim  = (g == 0) ? gen_a_timing_r : gen_b_timing_r;
      wire  [15:0] gate = tim[crate_regs_pkg::GATE_LSB +: 16];
      wire  [15:0] fine = tim[crate_regs_pkg::FINE_LSB +: 16];
      wire  [15:0] crs  = (g == 0) ? coarse_delay_ext_r[crate_regs_pkg::CRS_A_LSB +: 16]
                                   : coarse_delay_ext_r[crate_regs_pkg::CRS_B_LSB +: 16];
      wire         trg  = (g == 0) ? gen_a_trig : gen_b_trig;
      crate_regs_pkg::gen_state_type st_r;
      logic [47:0] cnt_r;
      wire  [47:0] dly  = 48'(fine) * 48'(crate_regs_pkg::TICK_CYC)
                        + 48'(crs) * 48'(CRS_CYC);
      always_ff @(posedge clk_sys)
      begin
        if (sys_rst)
        begin
          st_r <= crate_regs_pkg::GEN_IDLE;
          cnt_r <= '0;
          gen_out_r[g] <= 1'b0;
        end
        else if (clk_en)
        begin
          case (st_r)
            crate_regs_pkg::GEN_IDLE:
              if (trg || pulser_mode[g])
              begin
                st_r  <= crate_regs_pkg::GEN_DELAY;
                cnt_r <= dly;
              end
            crate_regs_pkg::GEN_DELAY:
              if (cnt_r <= 48'h1)
              begin
                st_r  <= crate_regs_pkg::GEN_GATE;
                cnt_r <= 48'(gate) * 48'(crate_regs_pkg::TICK_CYC);
                gen_out_r[g] <= (gate != 16'h0000);
              end
              else
                cnt_r <= cnt_r - 48'h1;
            crate_regs_pkg::GEN_GATE:
              if (cnt_r <= 48'h1)
              begin
                gen_out_r[g] <= 1'b0;
                // Pulser goes straight into the next delay: period = gate + delay
                st_r  <= pulser_mode[g] ? crate_regs_pkg::GEN_DELAY : crate_regs_pkg::GEN_IDLE;
                cnt_r <= dly;
              end
              else
                cnt_r <= cnt_r - 48'h1;
            default: st_r <= crate_regs_pkg::GEN_IDLE;
          endcase
        end
      end
    end
  endgenerate
  assign delay_gate_gen_a = gen_out_r[0];
  assign delay_gate_gen_b = gen_out_r[1];

  // ****************************************************************
  // Packet end and watchdog
  // ****************************************************************
  logic [7:0]  buf_cnt_r;
  logic [3:0]  sec_cnt_r;
  logic [31:0] tick_r;
  wire  [7:0]  nbuf  = bulk_transfer_setup_r[crate_regs_pkg::NBUF_LSB +: 8];
  wire  [3:0]  tmo   = bulk_transfer_setup_r[crate_regs_pkg::TMO_LSB +: 4];
  wire         multi = (nbuf != 8'h00);
  wire         bufs_in = buffer_done && (buf_cnt_r + 8'h1 >= nbuf);
  wire         wd_hit  = multi && (tick_r == 32'(SEC_CYC - 1)) && (sec_cnt_r == tmo);
  wire         pe_fire = multi ? (bufs_in || wd_hit) : (buffer_done || event_end);

  // Buffer bundling; the watchdog restarts with each packet end
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      buf_cnt_r  <= '0;
      sec_cnt_r  <= '0;
      tick_r     <= '0;
      packet_end <= 1'b0;
    end
    else if (clk_en)
    begin
      packet_end <= pe_fire;
      if (pe_fire)
      begin
        buf_cnt_r <= '0;
        sec_cnt_r <= '0;
        tick_r    <= '0;
      end
      else
      begin
        buf_cnt_r <= buf_cnt_r + 8'(buffer_done);
        tick_r    <= (tick_r == 32'(SEC_CYC - 1)) ? '0 : tick_r + 32'h1;
        if (tick_r == 32'(SEC_CYC - 1))
          sec_cnt_r <= sec_cnt_r + 4'h1;
      end
    end
  end

  // ****************************************************************
  // Pseudo commands: delay, marker, crate and broadcast
  // ****************************************************************
  logic [2:0]  pause_d_r;
  logic [7:0]  stall_r;
  // A pause pending on repeat stays armed until the repeat finishes
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pause_d_r <= '0;
      stall_r   <= '0;
      cmd_stall <= 1'b0;
    end
    else if (clk_en)
    begin
      if (is_pause)
      begin
        pause_d_r <= cmd_a[2:0];
        stall_r   <= 8'(crate_regs_pkg::PAUSE_CYC);
      end
      else if (cmd && cmd_repeat && pause_d_r != 3'h0)
        stall_r <= 8'(pause_d_r) * 8'(crate_regs_pkg::PAUSE_CYC);
      else if (stall_r != 8'h00)
        stall_r <= stall_r - 8'h01;
      // A new pause in the same cycle as repeat end stays armed
      if (repeat_done && !is_pause)
        pause_d_r <= '0;
      cmd_stall <= (stall_r > 8'h01) || is_pause;
    end
  end
  AST_PS: assert property (is_pause |=> cmd_stall) else $error("no pause stall");

  // Crate actions, broadcast and register reads
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      crate_init    <= 1'b0;
      crate_clear   <= 1'b0;
      crate_inhibit <= 1'b0;
      bcast_valid   <= 1'b0;
      bcast_sel     <= '0;
      bcast_a       <= '0;
      bcast_f       <= '0;
      bcast_data    <= '0;
      rd_valid      <= 1'b0;
      rd_data       <= '0;
    end
    else if (clk_en)
    begin
      crate_init  <= is_z;
      crate_clear <= is_c;
      if (is_seti)
        crate_inhibit <= 1'b1;
      else if (is_clri)
        crate_inhibit <= 1'b0;
      bcast_valid <= is_bc && (broadcast_select_map_r != '0);
      if (is_bc)
      begin
        bcast_sel  <= broadcast_select_map_r;
        bcast_a    <= cmd_a;
        bcast_f    <= cmd_f;
        bcast_data <= cmd_data;
      end
      rd_valid <= is_intr;
      if (is_intr)
        rd_data <= rd_mux;
    end
  end
  // Crate actions follow their command by one cycle
  AST_Z: assert property (is_z |=> crate_init) else $error("no init pulse");
  AST_C: assert property (is_c |=> crate_clear) else $error("no clear pulse");
  AST_SI: assert property (is_seti |=> crate_inhibit) else $error("inhibit not set");
  AST_CI: assert property (is_clri |=> !crate_inhibit) else $error("inhibit stuck");

  // Marker words are the only inserted words; no automatic end marks
  wire             mk_ready;
  wire [DATA_W:0]  mk_word = {cmd_word[crate_regs_pkg::WIDE_BIT],
                              cmd_word[crate_regs_pkg::WIDE_BIT] ? cmd_data
                                                                 : {16'h0000, cmd_data[15:0]}};
  logic            mk_v_r;
  logic [DATA_W:0] mk_d_r;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      mk_v_r <= 1'b0;
      mk_d_r <= '0;
    end
    else if (clk_en)
    begin
      mk_v_r <= is_mark && mk_ready;
      mk_d_r <= mk_word;
    end
  end
  AST_MK: assert property (is_mark && mk_ready |=> mk_v_r) else $error("marker lost");

  // Output FIFO; a marker arriving while the FIFO is full is dropped
  wire fifo_v;
  wire [DATA_W:0] fifo_d;
  word_fifo #(.WIDTH(DATA_W + 1), .DEPTH(FIFO_D)) u_fifo (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_valid  (mk_v_r),
    .in_data   (mk_d_r),
    .in_ready  (mk_ready),
    .out_valid (fifo_v),
    .out_data  (fifo_d),
    .out_ready (out_ready && !out_valid)
  );
  // Output stage register, one word every other cycle at most
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end
    else if (clk_en)
    begin
      out_valid <= fifo_v && out_ready && !out_valid;
      out_data  <= fifo_d;
    end
  end

endmodule : crate_ctrl_internal_regs

//--- crate_regs_pkg.sv
package crate_regs_pkg;

  // ****************************************************************
  // Command decode constants
  // ****************************************************************
  localparam logic [4:0] STN_MARK   = 5'h00;
  localparam logic [4:0] STN_INTERN = 5'h19;
  localparam logic [4:0] STN_BCAST  = 5'h1A;
  localparam logic [4:0] STN_MAP    = 5'h1B;
  localparam logic [4:0] STN_CRATE  = 5'h1C;
  localparam logic [4:0] STN_INHIB  = 5'h1D;

  localparam logic [4:0] FN_READ    = 5'h00;
  localparam logic [4:0] FN_WRITE   = 5'h10;
  localparam logic [4:0] FN_CRATE   = 5'h1D;
  localparam logic [4:0] FN_SET_I   = 5'h18;
  localparam logic [4:0] FN_CLR_I   = 5'h1A;
  localparam logic [3:0] SA_INIT    = 4'h8;
  localparam logic [3:0] SA_CLEAR   = 4'h9;
  localparam int         MAP_WR_BIT = 4;
  localparam int         WIDE_BIT   = 14;

  // ****************************************************************
  // Register subaddresses
  // ****************************************************************
  localparam logic [3:0] SA_GEN_A   = 4'h7;
  localparam logic [3:0] SA_GEN_B   = 4'h8;
  localparam logic [3:0] SA_LAM     = 4'h9;
  localparam logic [3:0] SA_CNT_A   = 4'hB;
  localparam logic [3:0] SA_CNT_B   = 4'hC;
  localparam logic [3:0] SA_COARSE  = 4'hD;
  localparam logic [3:0] SA_BULK    = 4'hE;
  localparam logic [3:0] SA_MAPCOPY = 4'hF;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int GATE_LSB   = 16;
  localparam int FINE_LSB   = 0;
  localparam int CRS_B_LSB  = 16;
  localparam int CRS_A_LSB  = 0;
  localparam int NBUF_LSB   = 0;
  localparam int TMO_LSB    = 8;
  localparam int MASK_W     = 24;
  localparam int STACK_DEPTH = 1024;
  localparam int STACK_W     = 16;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_NS        = 10;
  localparam int TICK_NS       = 10;
  localparam int TICK_CYC      = TICK_NS / CLK_NS;
  localparam int COARSE_NS     = 655360;
  localparam int COARSE_CYC    = COARSE_NS / CLK_NS;
  localparam int PAUSE_NS      = 100;
  localparam int PAUSE_CYC     = PAUSE_NS / CLK_NS;
  localparam int SECOND_NS     = 1000000000;
  localparam int SECOND_CYC    = SECOND_NS / CLK_NS;

  typedef enum logic [1:0] {
    GEN_IDLE  = 2'b00,
    GEN_DELAY = 2'b01,
    GEN_GATE  = 2'b10
  } gen_state_type;

endpackage : crate_regs_pkg

//--- word_fifo.sv
`timescale 1ns/100ps

module word_fifo #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  // Honest flags from the occupancy count
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rd_r];

  // Pointers and storage
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end
    else if (clk_en)
    begin
      if (push)
      begin
        mem_r[wr_r] <= in_data;
        wr_r        <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop)
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule : word_fifo

//--- stream_sink.sv
`timescale 1ns/100ps

// ****************************************************************
// Far side of the output data stream
// ****************************************************************
module stream_sink (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  // Stream from the block
  input  wire logic        out_valid,
  input  wire logic [32:0] out_data,
  output logic             out_ready,
  // Bench control and view
  input  wire logic        stall,
  output logic [32:0]      last_word,
  output int               word_cnt
);
  // Ready drops while stalled
  assign out_ready = !stall;
  // Take one word per accepted cycle
  always @(posedge clk_sys)
  begin
    if (sys_rst)
      word_cnt <= 0;
    else if (out_valid === 1'b1 && out_ready)
    begin
      last_word <= out_data;
      word_cnt  <= word_cnt + 1;
    end
  end
endmodule : stream_sink

//--- crate_ctrl_internal_regs_test.sv
`timescale 1ns/100ps

module crate_ctrl_internal_regs_test;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        clk_sys, sys_rst, cmd_valid, acquire, nim_in, stall, rp, stl, b_q;
  logic [6:0]  pv; // Pulsed inputs by index, see the uut pins
  logic        out_ready, out_valid, rd_valid, ev_trig, pe, ga, gb, ci, cc, inh, bv;
  logic [4:0]  cmd_n, cmd_f;
  logic [3:0]  cmd_a;
  logic [1:0]  pulser_mode;
  logic [9:0]  stack_addr;
  logic [15:0] cmd_word, stack_wdata, stack_rdata;
  logic [23:0] lam_req, bsel, bs;
  logic [31:0] cmd_data, rd_data, bdata, bd, last_rd, v;
  logic [32:0] out_data, last_word;
  int          word_cnt, n_init, n_clr, n_bc, n_pe, a_hi, t, b_rise, b_per;
  int          mismatches = 0, num_checks = 0;
  // Short counts keep the run brief
  crate_ctrl_internal_regs #(.SEC_CYC(100), .CRS_CYC(4)) uut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(1'b1), .cmd_valid(cmd_valid),
    .cmd_n(cmd_n), .cmd_a(cmd_a), .cmd_f(cmd_f), .cmd_word(cmd_word),
    .cmd_data(cmd_data), .cmd_repeat(rp), .stack_start(pv[2]),
    .repeat_done(pv[6]), .cmd_stall(stl), .rd_valid(rd_valid), .rd_data(rd_data),
    .stack_we(pv[3]), .stack_addr(stack_addr), .stack_wdata(stack_wdata),
    .stack_rdata(stack_rdata), .acquire(acquire), .lam_req(lam_req),
    .nim_in(nim_in), .gen_a_trig(pv[0]), .gen_b_trig(1'b0),
    .count_a_in(pv[1]), .count_b_in(1'b0), .buffer_done(pv[4]),
    .event_end(pv[5]), .event_trigger(ev_trig), .packet_end(pe),
    .delay_gate_gen_a(ga), .delay_gate_gen_b(gb), .pulser_mode(pulser_mode),
    .crate_init(ci), .crate_clear(cc), .crate_inhibit(inh), .bcast_valid(bv),
    .bcast_sel(bsel), .bcast_a(), .bcast_f(), .bcast_data(bdata),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
  stream_sink sink (.clk_sys(clk_sys), .sys_rst(sys_rst), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready), .stall(stall),
    .last_word(last_word), .word_cnt(word_cnt));
  // Clock at 40 ns
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = !clk_sys;
  end
  // Monitor of answers, pulses and generator timing
  always @(posedge clk_sys)
  begin
    if (rd_valid === 1'b1) last_rd <= rd_data;
    if (bv === 1'b1) {bs, bd} <= {bsel, bdata};
    n_init <= n_init + (ci === 1'b1);
    n_clr  <= n_clr + (cc === 1'b1);
    n_bc   <= n_bc + (bv === 1'b1);
    n_pe   <= n_pe + (pe === 1'b1);
    a_hi   <= a_hi + (ga === 1'b1);
    b_q    <= gb;
    t      <= t + 1;
    if (gb === 1'b1 && b_q === 1'b0)
    begin
      b_per  <= t - b_rise;
      b_rise <= t;
    end
  end
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  task cmd(input logic [4:0] n, input logic [3:0] a, input logic [4:0] f,
           input logic [31:0] d, input logic [15:0] w);
    @(posedge clk_sys);
    cmd_valid <= 1'b1;
    cmd_n     <= n;
    cmd_a     <= a;
    cmd_f     <= f;
    cmd_data  <= d;
    cmd_word  <= w;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask : cmd
  task rd(input logic [3:0] a, output logic [31:0] r);
    last_rd = 32'hDEAD_BEEF;
    cmd(5'h19, a, 5'h00, 32'h0, 16'h0);
    r = last_rd;
  endtask : rd
  task pulse(input int i, input int hold);
    pv[i] <= 1'b1;
    repeat (hold) @(posedge clk_sys);
    pv[i] <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : pulse
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Register read-back and a read-only place
  task t_regs;
    logic [3:0]  ad [5];
    logic [31:0] va [5];
    ad = '{4'h7, 4'h8, 4'h9, 4'hD, 4'hE};
    va = '{32'h0003_0002, 32'h0002_0003, 32'h0000_0005, 32'h0001_0000, 32'h0000_0100};
    foreach (ad[i]) cmd(5'h19, ad[i], 5'h10, va[i], 16'h0);
    foreach (ad[i])
    begin
      rd(ad[i], v);
      check("reg", v, va[i]);
    end
    cmd(5'h19, 4'hB, 5'h10, 32'h5555_5555, 16'h0);
    rd(4'hB, v);
    check("count_a_ro", v, 32'h0);
    $display("t_regs done");
  endtask : t_regs
  // Single shot on A, free-running pulser on B with one coarse step
  task t_gen;
    a_hi = 0;
    pulse(0, 1);
    repeat (40) @(posedge clk_sys);
    check("gate_a_len", a_hi, 33'd3);
    pulser_mode <= 2'b10;
    repeat (40) @(posedge clk_sys);
    check("pulser_b_period", b_per, 33'd9);
    pulser_mode <= 2'b00;
    $display("t_gen done");
  endtask : t_gen
  // Masked LAM trigger, then NIM trigger with a zero mask
  task t_lam;
    acquire <= 1'b1;
    lam_req <= 24'h00_0005;
    repeat (4) @(posedge clk_sys);
    check("lam_all", ev_trig, 1'b1);
    lam_req <= 24'h00_0001;
    repeat (4) @(posedge clk_sys);
    check("lam_part", ev_trig, 1'b0);
    cmd(5'h19, 4'h9, 5'h10, 32'h0, 16'h0);
    nim_in <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check("nim_trig", ev_trig, 1'b1);
    nim_in  <= 1'b0;
    acquire <= 1'b0;
    $display("t_lam done");
  endtask : t_lam
  // Interactive snapshot of counter A at stack start
  task t_cnt;
    pulse(1, 5);
    pulse(2, 1);
    rd(4'hB, v);
    check("count_a_snap", v, 32'h5);
    $display("t_cnt done");
  endtask : t_cnt
  // Stray byte, rewind by another command, full map, notepad, broadcast
  task t_map;
    cmd(5'h1B, 4'hF, 5'h1F, 32'h0, 16'h0);
    rd(4'h1, v);
    cmd(5'h1B, 4'h1, 5'h12, 32'h0, 16'h0);
    cmd(5'h1B, 4'h3, 5'h14, 32'h0, 16'h0);
    cmd(5'h1B, 4'h5, 5'h16, 32'h0, 16'h0);
    rd(4'hF, v);
    check("map_copy", v, 32'h0065_4321);
    cmd(5'h1A, 4'h2, 5'h10, 32'h0000_ABCD, 16'h0);
    check("bcast_cnt", n_bc, 33'd1);
    check("bcast_sel", bs, 33'h65_4321);
    check("bcast_data", bd, 33'hABCD);
    $display("t_map done");
  endtask : t_map
  // Crate initialise, clear, inhibit set and clear
  task t_crate;
    cmd(5'h1C, 4'h8, 5'h1D, 32'h0, 16'h0);
    cmd(5'h1C, 4'h9, 5'h1D, 32'h0, 16'h0);
    check("init_clr", {n_init[15:0], n_clr[15:0]}, {16'd1, 16'd1});
    cmd(5'h1D, 4'h9, 5'h18, 32'h0, 16'h0);
    check("inhibit_set", inh, 1'b1);
    cmd(5'h1D, 4'h9, 5'h1A, 32'h0, 16'h0);
    check("inhibit_clr", inh, 1'b0);
    $display("t_crate done");
  endtask : t_crate
  // Held wide marker, packet ends, no extra words
  task t_stream;
    stall <= 1'b1;
    cmd(5'h00, 4'h0, 5'h10, 32'h1234_5678, 16'h4000);
    check("held", word_cnt, 33'd0);
    stall <= 1'b0;
    repeat (6) @(posedge clk_sys);
    check("marker", last_word, {1'b1, 32'h1234_5678});
    pulse(4, 1);
    pulse(5, 1);
    check("pe_default", n_pe, 33'd2);
    cmd(5'h19, 4'hE, 5'h10, 32'h0000_0002, 16'h0);
    pulse(4, 1);
    check("pe_one_buf", n_pe, 33'd2);
    pulse(4, 1);
    check("pe_two_buf", n_pe, 33'd3);
    check("no_auto_mark", word_cnt, 33'd1);
    $display("t_stream done");
  endtask : t_stream
  // Last stack word written and read back
  task t_stack;
    stack_addr  <= 10'h3FF;
    stack_wdata <= 16'hA5C3;
    pulse(3, 1);
    check("stack_top", stack_rdata, 16'hA5C3);
    $display("t_stack done");
  endtask : t_stack
  // Pause of 3 stretches the next repeat; repeat end disarms it
  task t_pause;
    rp <= 1'b1;
    cmd(5'h00, 4'h3, 5'h00, 32'h0, 16'h0);
    rd(4'h1, v);
    repeat (20) @(posedge clk_sys);
    check("rep_stall", stl, 1'b1);
    pulse(6, 10);
    rd(4'h1, v);
    check("pause_clr", stl, 1'b0);
    $display("t_pause done");
  endtask : t_pause
  // ****************************************************************
  // Main sequence and watchdog
  // ****************************************************************
  initial
  begin
    {cmd_valid, acquire, nim_in, stall, rp, pv, pulser_mode} = '0;
    {cmd_n, cmd_a, cmd_f, cmd_word, cmd_data, lam_req, stack_addr} = '0;
    {stack_wdata, n_init, n_clr, n_bc, n_pe, a_hi, t, b_rise, b_per} = '0;
    sys_rst = 1'b1;
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_regs;
    t_gen;
    t_lam;
    t_cnt;
    t_map;
    t_crate;
    t_stream;
    t_stack;
    t_pause;
    wrap_up;
  end
  // A hang ends the run as a failure
  initial
  begin
    #200000;
    mismatches++;
    wrap_up;
  end
endmodule : crate_ctrl_internal_regs_test
